/* design/aub_uart.sv */
// Asynchronous serial transceiver with baud generator and AHB-Lite registers
// Contract
// - Transmit-only mode sends LSB first on CMOS output; receive pin stays port.
// - Baud pin is clock input only with external source in UART mode.
// - Error status valid in async mode only; reset clears it to zero.
// - Parity error when received parity mismatches configured parity mode.
// - Framing error when stop bit not found at expected position.
// - Receiver checks only one stop bit even with two configured.
// - Overrun error when a reception completes before buffer is read.
// - Until buffer read after overrun, every new reception flags overrun.
// - Prescaler codes 0 to 7 give system clock over 2^n, n 1..8.
// - Code 8 selects external baud pin in UART mode; others prohibited.
// - Internal bit rate is system clock over 2^n over 16.
// - External bit rate is baud pin frequency over 16.
// - Parity codes: none, zero with no check, odd, even.
// - Length bit selects 7 data bits clear, 8 data bits set.
// - Stop length bit makes transmitter send one or two stop bits.
`timescale 1ns/1ns
module aub_uart (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  input wire logic external_baud_clock_pin,
  // Pin function indication, high when the serial function owns the pin
  output logic rx_pin_serial,
  output logic baud_pin_serial
);
  import aub_pkg::*;

  typedef struct packed {
    logic [7:0] am;
    logic [7:0] sm;
    logic [7:0] brg;
    logic [7:0] err;
    logic [7:0] rxbuf;
    logic rx_full;
    logic [7:0] rdata;
    logic wr_pend;
    logic [15:0] wr_idx;
    aub_rx_t rx_st;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    aub_tx_t tx_st;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txd;
    logic tx_oe;
    logic rx_fn;
    logic baud_fn;
    logic hready_q;
  } aub_state_t;

  aub_state_t s;
  aub_state_t next_s;
  logic tick;
  logic uart_mode;
  logic tx_en;
  logic rx_en;
  logic addr_ok;
  logic [15:0] a_idx;
  logic rx_done;
  logic rx_read;
  logic [7:0] rx_data;
  logic par_bad;
  logic stop_bad;
  logic tx_load;
  logic [2:0] rx_last;
  logic [2:0] tx_last;
  aub_par_t pmode;

  function automatic logic [31:0] aub_byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction : aub_byte_addr

  // Parity bit that the configured mode expects for a character
  function automatic logic aub_parity(input aub_par_t m, input logic [7:0] d);
    logic p;
    p = 1'b0;
    if (m == PAR_ODD) begin
      p = ~(^d);
    end else if (m == PAR_EVEN) begin
      p = ^d;
    end
    return p;
  endfunction : aub_parity

  aub_baud_gen u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .prescaler_code(s.brg[PSC_LSB+3:PSC_LSB]),
    .uart_mode(uart_mode),
    .external_baud_clock_pin(external_baud_clock_pin),
    .tick(tick)
  );

  always_comb begin
    next_s = s;
    pmode = aub_par_t'({s.am[AM_PS_HI], s.am[AM_PS_LO]});
    uart_mode = ~s.sm[SM_CSIE] & (s.am[AM_TXE] | s.am[AM_RXE]);
    tx_en = s.am[AM_TXE] & ~s.sm[SM_CSIE];
    rx_en = s.am[AM_RXE] & ~s.sm[SM_CSIE];
    rx_last = s.am[AM_CL] ? DLAST_8 : DLAST_7;
    tx_last = rx_last;
    rx_data = s.am[AM_CL] ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
    par_bad = (pmode == PAR_ODD || pmode == PAR_EVEN)
      && (aub_parity(pmode, rx_data) != s.rx_par);
    stop_bad = ~serial_rx_pin;
    rx_done = 1'b0;
    tx_load = 1'b0;
    next_s.hready_q = 1'b1;
    // Bus address phase
    a_idx = haddr[17:2];
    addr_ok = hsel && hready && htrans[1];
    next_s.wr_pend = 1'b0;
    rx_read = 1'b0;
    if (addr_ok) begin
      next_s.rdata = 8'h00;
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_idx = a_idx;
      end
      if (haddr != aub_byte_addr(a_idx)) begin
        next_s.wr_pend = 1'b0;
      end else if (!hwrite) begin
        unique case (a_idx)
          IDX_ASYNC_MODE: next_s.rdata = s.am;
          IDX_ERR_STATUS: next_s.rdata = s.err;
          IDX_SYNC_MODE: next_s.rdata = s.sm;
          IDX_BAUD_CTRL: next_s.rdata = s.brg & BAUD_CTRL_MASK;
          IDX_RX_BUFFER: begin
            next_s.rdata = s.rxbuf;
            rx_read = 1'b1;
          end
          IDX_LINE_STATUS: begin
            next_s.rdata[LS_TX_BUSY] = (s.tx_st != TX_IDLE);
            next_s.rdata[LS_RX_FULL] = s.rx_full;
          end
          default: next_s.rdata = 8'h00;
        endcase
      end
    end
    if (rx_read) begin
      next_s.rx_full = 1'b0;
    end
    // Bus data phase writes
    if (s.wr_pend) begin
      unique case (s.wr_idx)
        IDX_ASYNC_MODE: next_s.am = hwdata[7:0] & ASYNC_MODE_MASK;
        IDX_SYNC_MODE: next_s.sm = hwdata[7:0] & SYNC_MODE_MASK;
        IDX_BAUD_CTRL: next_s.brg = hwdata[7:0] & BAUD_CTRL_MASK;
        IDX_TX_BUFFER: tx_load = (s.tx_st == TX_IDLE) && tx_en;
        default: next_s.rdata = next_s.rdata;
      endcase
    end
    // Receiver
    unique case (s.rx_st)
      RX_IDLE: begin
        if (rx_en && tick && !serial_rx_pin) begin
          next_s.rx_st = RX_START;
          next_s.rx_ovs = 4'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          next_s.rx_ovs = s.rx_ovs + 4'h1;
          if (s.rx_ovs == OVS_MID) begin
            // A glitch shorter than half a bit is not a start
            next_s.rx_st = serial_rx_pin ? RX_IDLE : RX_DATA;
            next_s.rx_ovs = 4'h0;
            next_s.rx_bit = BIT_FIRST;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_s.rx_ovs = s.rx_ovs + 4'h1;
          if (s.rx_ovs == OVS_LAST) begin
            next_s.rx_sh = {serial_rx_pin, s.rx_sh[7:1]};
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == rx_last) begin
              next_s.rx_st = (pmode == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          next_s.rx_ovs = s.rx_ovs + 4'h1;
          if (s.rx_ovs == OVS_LAST) begin
            next_s.rx_par = serial_rx_pin;
            next_s.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_s.rx_ovs = s.rx_ovs + 4'h1;
          if (s.rx_ovs == OVS_LAST) begin
            // One stop bit sampled; a second one is never checked
            rx_done = 1'b1;
            next_s.rx_st = RX_IDLE;
          end
        end
      end
    endcase
    if (!rx_en) begin
      next_s.rx_st = RX_IDLE;
    end
    if (rx_done) begin
      next_s.rxbuf = rx_data;
      next_s.rx_full = 1'b1;
      if (uart_mode) begin
        next_s.err[ERR_PE] = par_bad;
        next_s.err[ERR_FE] = stop_bad;
        next_s.err[ERR_OVE] = s.rx_full;
      end
    end
    // Transmitter, LSB first
    unique case (s.tx_st)
      TX_IDLE: begin
        next_s.txd = 1'b1;
        if (tx_load) begin
          next_s.tx_sh = hwdata[7:0];
          next_s.tx_par = aub_parity(pmode, s.am[AM_CL] ? hwdata[7:0]
            : {1'b0, hwdata[6:0]});
          next_s.tx_st = TX_START;
          next_s.tx_ovs = 4'h0;
          next_s.txd = 1'b0;
        end
      end
      TX_START: begin
        if (tick) begin
          next_s.tx_ovs = s.tx_ovs + 4'h1;
          if (s.tx_ovs == OVS_LAST) begin
            next_s.tx_st = TX_DATA;
            next_s.tx_bit = BIT_FIRST;
            next_s.txd = s.tx_sh[0];
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          next_s.tx_ovs = s.tx_ovs + 4'h1;
          if (s.tx_ovs == OVS_LAST) begin
            next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
            next_s.tx_bit = s.tx_bit + 3'h1;
            next_s.txd = s.tx_sh[1];
            if (s.tx_bit == tx_last) begin
              next_s.tx_bit = BIT_FIRST;
              next_s.tx_st = (pmode == PAR_NONE) ? TX_STOP : TX_PAR;
              next_s.txd = (pmode == PAR_NONE) ? 1'b1 : s.tx_par;
            end
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          next_s.tx_ovs = s.tx_ovs + 4'h1;
          if (s.tx_ovs == OVS_LAST) begin
            next_s.tx_st = TX_STOP;
            next_s.txd = 1'b1;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          next_s.tx_ovs = s.tx_ovs + 4'h1;
          if (s.tx_ovs == OVS_LAST) begin
            next_s.tx_bit = s.tx_bit + 3'h1;
            if (!s.am[AM_SL] || s.tx_bit == STOP_SECOND) begin
              next_s.tx_st = TX_IDLE;
            end
          end
        end
      end
    endcase
    if (!tx_en) begin
      next_s.tx_st = TX_IDLE;
      next_s.txd = 1'b1;
    end
    // Pin ownership
    next_s.tx_oe = tx_en;
    next_s.rx_fn = rx_en;
    next_s.baud_fn = uart_mode
      && (s.brg[PSC_LSB+3:PSC_LSB] == PSC_EXT);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.am <= REG_RESET;
      s.sm <= REG_RESET;
      s.brg <= REG_RESET;
      s.err <= REG_RESET;
      s.rx_st <= RX_IDLE;
      s.tx_st <= TX_IDLE;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = {24'h000000, s.rdata};
  assign hreadyout = s.hready_q;
  assign hresp = 1'b0;
  assign serial_tx_pin = s.txd;
  assign serial_tx_oe = s.tx_oe;
  assign rx_pin_serial = s.rx_fn;
  assign baud_pin_serial = s.baud_fn;

  AST_OVERRUN: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done && uart_mode && s.rx_full |=> s.err[ERR_OVE] && s.rx_full)
    else $error("overrun not flagged");
  AST_NO_OVERRUN: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done && uart_mode && !s.rx_full |=> !s.err[ERR_OVE])
    else $error("overrun flagged with empty buffer");
  AST_FRAMING: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done && uart_mode |=> s.err[ERR_FE] == $past(stop_bad))
    else $error("framing flag does not follow stop sample");
  AST_PARITY_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done && uart_mode && !pmode[1] |=> !s.err[ERR_PE])
    else $error("parity error without parity check");
  AST_BUF_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done |=> s.rxbuf == $past(rx_data) && s.rx_full)
    else $error("received character not stored");
  AST_ONE_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.rx_st == RX_STOP) && tick && (s.rx_ovs == OVS_LAST)
    |=> s.rx_st == RX_IDLE)
    else $error("receiver waits for a second stop bit");
  AST_BRG_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.brg & ~BAUD_CTRL_MASK) == 8'h00 && hrdata[31:8] == 24'h000000)
    else $error("unused bits read nonzero");
  AST_BAUD_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_pin_serial |-> $past(uart_mode)
    && $past(s.brg[PSC_LSB+3:PSC_LSB]) == PSC_EXT)
    else $error("baud pin taken without external source");
  AST_TX_OE: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 serial_tx_oe == $past(tx_en) && (rx_pin_serial == $past(rx_en)))
    else $error("pin ownership wrong");
  AST_TX_START: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_load |=> !serial_tx_pin && s.tx_st == TX_START)
    else $error("start bit not driven");
  AST_ERR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_done |=> $stable(s.err))
    else $error("error status changed between characters");

  CVR_OVERRUN: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_done && s.rx_full);
  CVR_FRAMING: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_done && stop_bad);
  CVR_PARITY: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_done && par_bad);
  CVR_TWO_STOP: cover property (@(posedge hclk) disable iff (!hresetn)
    (s.tx_st == TX_STOP) && s.am[AM_SL] && (s.tx_bit == STOP_SECOND));
endmodule : aub_uart

/* pkg/aub_pkg.sv */
// Shared constants and types of the asynchronous serial block
package aub_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_ASYNC_MODE = 16'hff70;
  localparam logic [15:0] IDX_ERR_STATUS = 16'hff71;
  localparam logic [15:0] IDX_SYNC_MODE = 16'hff72;
  localparam logic [15:0] IDX_BAUD_CTRL = 16'hff73;
  localparam logic [15:0] IDX_RX_BUFFER = 16'hff74;
  localparam logic [15:0] IDX_TX_BUFFER = 16'hff75;
  localparam logic [15:0] IDX_LINE_STATUS = 16'hff76;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bit masks
  localparam logic [7:0] ASYNC_MODE_MASK = 8'hfc;
  localparam logic [7:0] SYNC_MODE_MASK = 8'hcf;
  localparam logic [7:0] BAUD_CTRL_MASK = 8'hf0;
  // Async mode fields
  localparam int AM_TXE = 7;
  localparam int AM_RXE = 6;
  localparam int AM_PS_HI = 5;
  localparam int AM_PS_LO = 4;
  localparam int AM_CL = 3;
  localparam int AM_SL = 2;
  // Sync mode fields
  localparam int SM_CSIE = 7;
  localparam int SM_DIR = 2;
  localparam int SM_CSCK = 1;
  // Error status and line status fields
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  localparam int LS_TX_BUSY = 1;
  localparam int LS_RX_FULL = 0;
  // Baud generator codes, upper nibble of the control register
  localparam int PSC_LSB = 4;
  localparam logic [3:0] PSC_MAX_INT = 4'h7;
  localparam logic [3:0] PSC_EXT = 4'h8;
  localparam logic [8:0] PSC_BASE = 9'h002;
  // Sixteen ticks per bit
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [2:0] DLAST_8 = 3'h7;
  localparam logic [2:0] DLAST_7 = 3'h6;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] STOP_SECOND = 3'h1;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } aub_par_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } aub_rx_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } aub_tx_t;
endpackage : aub_pkg

/* design/aub_baud_gen.sv */
// Baud tick generator: sixteen ticks per bit from prescaler or pin
`timescale 1ns/1ns
module aub_baud_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire logic [3:0] prescaler_code,
  input wire logic uart_mode,
  // External baud clock pin
  input wire logic external_baud_clock_pin,
  // Oversampling tick
  output logic tick
);
  import aub_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic ext_q;
    logic tick;
  } aub_bg_state_t;

  aub_bg_state_t s;
  aub_bg_state_t next_s;
  logic [7:0] limit;
  logic ext_rise;

  // Low n bits all ones marks the end of a 2^n period
  function automatic logic [7:0] aub_limit(input logic [3:0] code);
    logic [8:0] v;
    v = (PSC_BASE << code[2:0]) - 9'h001;
    return v[7:0];
  endfunction : aub_limit

  always_comb begin
    next_s = s;
    limit = aub_limit(prescaler_code);
    ext_rise = external_baud_clock_pin & ~s.ext_q;
    next_s.cnt = s.cnt + 8'h01;
    next_s.ext_q = external_baud_clock_pin;
    next_s.tick = 1'b0;
    if (prescaler_code <= PSC_MAX_INT) begin
      next_s.tick = ((s.cnt & limit) == limit);
    end else if (prescaler_code == PSC_EXT && uart_mode) begin
      // Pin edge only in UART mode; other codes give no clock
      next_s.tick = ext_rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  // Code must hold over the whole period; the counter runs free, so a rewrite keeps the phase
  AST_TICK_N2: assert property (@(posedge hclk) disable iff (!hresetn)
    (prescaler_code == 4'h1) && $stable(prescaler_code) && tick
    ##1 (prescaler_code == 4'h1) [*3]
    |-> ##1 (tick && !$past(tick) && !$past(tick, 2)
    && !$past(tick, 3)))
    else $error("n=2 tick period is not four cycles");
  AST_EXT_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
    (prescaler_code == PSC_EXT) && uart_mode && ext_rise |=> tick)
    else $error("external pin edge gave no tick");
  AST_PROHIBITED: assert property (@(posedge hclk) disable iff (!hresetn)
    (prescaler_code > PSC_EXT) && $stable(prescaler_code) |=> !tick)
    else $error("prohibited prescaler code produced a tick");
  CVR_EXT: cover property (@(posedge hclk) disable iff (!hresetn)
    (prescaler_code == PSC_EXT) && tick);
endmodule : aub_baud_gen

/* sim/aub_serial_peer.sv */
// Remote asynchronous transceiver on the far side of the data lines
`timescale 1ns/1ns
module aub_serial_peer (
  // Clock
  input wire logic hclk,
  // Bit length in clock cycles and bits captured after the start bit
  input wire logic [15:0] bit_cycles,
  input wire logic [3:0] cap_n,
  // Lines, idle high
  input wire logic line_in,
  output logic line_out,
  // Last frame captured
  output logic [11:0] cap,
  output logic [7:0] frames
);
  initial begin
    line_out = 1'b1;
    cap = 12'h000;
    frames = 8'h00;
  end

  // Start bit, n bits LSB first, then gap bit times of idle mark
  task automatic send(input logic [11:0] f, input int n, input int gap);
    for (int i = -1; i < n + gap; i++) begin
      @(posedge hclk);
      line_out <= (i < 0) ? 1'b0 : (i < n) ? f[i] : 1'b1;
      repeat (bit_cycles - 1) @(posedge hclk);
    end
  endtask : send

  // Sample mid-bit from the falling edge of a start bit
  always begin
    logic [11:0] c;
    @(negedge line_in);
    repeat (bit_cycles / 2) @(posedge hclk);
    c = 12'h000;
    for (int i = 0; i < cap_n; i++) begin
      repeat (bit_cycles) @(posedge hclk);
      c[i] = line_in;
    end
    cap <= c;
    frames <= frames + 8'h01;
  end
endmodule : aub_serial_peer

/* sim/testbench.sv */
// Bench: register bus tasks, frames exchanged with the remote peer
`timescale 1ns/1ns
module testbench;
  import aub_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic serial_rx_pin, serial_tx_pin, serial_tx_oe, tx_line;
  logic ext_pin, rx_pin_serial, baud_pin_serial;
  logic [2:0] ext_cnt = 3'h0;
  logic [15:0] bit_cycles = 16'h0040;
  logic [3:0] cap_n = 4'h0;
  logic [11:0] cap;
  logic [7:0] frames;
  int fails = 0;
  int n_tests = 0;
  localparam logic [7:0] TX_AM [5] = '{8'h88, 8'h94, 8'hac, 8'hb0, 8'hbc};
  localparam logic [7:0] TX_D [5] = '{8'ha5, 8'hd3, 8'h3c, 8'h5a, 8'h81};
  localparam logic [3:0] TX_CODE [5] = '{4'h1, 4'h2, 4'h1, 4'h3, 4'h8};
  localparam logic [7:0] RX_AM [5] = '{8'h78, 8'h68, 8'h58, 8'h40, 8'h48};
  localparam logic [7:0] RX_D [5] = '{8'h96, 8'h31, 8'hc4, 8'he5, 8'h7e};
  localparam logic [11:0] RX_FLIP [5] = '{12'h0, 12'h100, 12'h100, 12'h0,
                                          12'h100};
  localparam logic [7:0] RX_ERR [5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h02};

  // Undriven transmit pin is pulled up on the line
  assign tx_line = serial_tx_oe ? serial_tx_pin : 1'b1;
  assign ext_pin = ext_cnt[2];
  always @(posedge hclk) ext_cnt <= ext_cnt + 3'h1;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  aub_uart dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe),
    .external_baud_clock_pin(ext_pin), .rx_pin_serial(rx_pin_serial),
    .baud_pin_serial(baud_pin_serial)
  );

  aub_serial_peer peer (
    .hclk(hclk), .bit_cycles(bit_cycles), .cap_n(cap_n),
    .line_in(tx_line), .line_out(serial_rx_pin), .cap(cap), .frames(frames)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_ready();
    int k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask : wait_ready

  task automatic bus(input logic [15:0] idx, input logic wr_en,
                     input logic [7:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {14'h0000, idx, 2'b00};
    hwrite <= wr_en;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [15:0] idx,
                        input logic [7:0] e);
    logic [31:0] q;
    bus(idx, 1'b0, 8'h00, q);
    check(what, q, {24'h000000, e});
    check("bus response", {31'h00000000, hresp}, 32'h00000000);
  endtask : rd_chk

  // Polls the line status register, bounded
  task automatic wait_status(input int b, input logic v);
    logic [31:0] q;
    int k = 0;
    do begin
      bus(IDX_LINE_STATUS, 1'b0, 8'h00, q);
      k++;
    end while (q[b] !== v && k < 5000);
    if (q[b] !== v) begin
      fails++;
      wrap_up();
    end
  endtask : wait_status

  task automatic wait_frame(input logic [7:0] old);
    int k = 0;
    while (frames === old && k < 8000) begin
      @(posedge hclk);
      k++;
    end
    if (frames === old) begin
      fails++;
      wrap_up();
    end
  endtask : wait_frame

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    wait_ready();
  endtask : do_reset

  // Frame bits after the start bit, LSB first, with their count
  function automatic logic [11:0] mkframe(input logic [7:0] d,
    input logic [7:0] am, output logic [3:0] n);
    logic [11:0] f;
    logic [7:0] dd;
    int k;
    dd = am[AM_CL] ? d : {1'b0, d[6:0]};
    f = {4'h0, dd};
    k = am[AM_CL] ? 8 : 7;
    if (am[AM_PS_HI] | am[AM_PS_LO]) begin
      f[k] = am[AM_PS_HI] & (am[AM_PS_LO] ? ^dd : ~^dd);
      k++;
    end
    f[k] = 1'b1;
    f[k + 1] = am[AM_SL];
    n = 4'(k + 1 + int'(am[AM_SL]));
    return f;
  endfunction : mkframe

  initial begin
    logic [11:0] f;
    logic [3:0] n;
    logic [7:0] old;
    logic [7:0] e;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    do_reset();
    rd_chk("error status reset", IDX_ERR_STATUS, 8'h00);
    rd_chk("baud control reset", IDX_BAUD_CTRL, 8'h00);
    wr(IDX_BAUD_CTRL, 8'hff);
    rd_chk("baud control low nibble", IDX_BAUD_CTRL, 8'hf0);
    wr(IDX_ERR_STATUS, 8'hff);
    rd_chk("error status read only", IDX_ERR_STATUS, 8'h00);
    rd_chk("unmapped", 16'hff77, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      // Written only while the transmitter is idle
      wr(IDX_BAUD_CTRL, {TX_CODE[i], 4'h0});
      wr(IDX_ASYNC_MODE, TX_AM[i]);
      bit_cycles = (TX_CODE[i] == PSC_EXT) ? 16'd128
                   : 16'd16 << (TX_CODE[i] + 4'h1);
      f = mkframe(TX_D[i], TX_AM[i], n);
      cap_n = n;
      repeat (2) @(posedge hclk);
      check("tx enable", serial_tx_oe, 1'b1);
      check("rx pin serial", rx_pin_serial, 1'b0);
      check("baud pin", baud_pin_serial, TX_CODE[i] == PSC_EXT);
      old = frames;
      wr(IDX_TX_BUFFER, TX_D[i]);
      wait_frame(old);
      check("tx frame", cap, f);
      wait_status(LS_TX_BUSY, 1'b0);
      $display("test tx frame %0d done", i);
    end
    wr(IDX_SYNC_MODE, 8'h80);
    repeat (2) @(posedge hclk);
    check("baud pin sync", baud_pin_serial, 1'b0);
    check("tx enable sync", serial_tx_oe, 1'b0);
    wr(IDX_SYNC_MODE, 8'h00);
    wr(IDX_BAUD_CTRL, 8'h10);
    bit_cycles = 16'd64;
    wr(IDX_ASYNC_MODE, 8'h7c);
    repeat (2) @(posedge hclk);
    check("rx pin serial", rx_pin_serial, 1'b1);
    // Two frames back to back with a single stop bit, buffer left unread
    f = mkframe(8'h4e, 8'h78, n);
    peer.send(f, n, 0);
    f = mkframe(8'hb1, 8'h78, n);
    peer.send(f, n, 1);
    wait_status(LS_RX_FULL, 1'b1);
    rd_chk("overrun", IDX_ERR_STATUS, 8'h01);
    f = mkframe(8'h2d, 8'h78, n);
    peer.send(f, n, 1);
    rd_chk("overrun again", IDX_ERR_STATUS, 8'h01);
    rd_chk("data after overrun", IDX_RX_BUFFER, 8'h2d);
    f = mkframe(8'h6a, 8'h78, n);
    peer.send(f, n, 1);
    wait_status(LS_RX_FULL, 1'b1);
    rd_chk("overrun cleared", IDX_ERR_STATUS, 8'h00);
    rd_chk("data", IDX_RX_BUFFER, 8'h6a);
    $display("test overrun done");
    // Framing error last: its low stop bit may open a false start
    for (int i = 0; i < 5; i++) begin
      wr(IDX_ASYNC_MODE, RX_AM[i]);
      f = mkframe(RX_D[i], RX_AM[i], n) ^ RX_FLIP[i];
      peer.send(f, n, 1);
      wait_status(LS_RX_FULL, 1'b1);
      e = RX_AM[i][AM_CL] ? RX_D[i] : {1'b0, RX_D[i][6:0]};
      rd_chk("rx errors", IDX_ERR_STATUS, RX_ERR[i]);
      rd_chk("rx data", IDX_RX_BUFFER, e);
      $display("test rx frame %0d done", i);
    end
    do_reset();
    rd_chk("error status reset", IDX_ERR_STATUS, 8'h00);
    rd_chk("baud control reset", IDX_BAUD_CTRL, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule : testbench
